// [inc/bfr_pkg.sv]
package bfr_pkg;
  // stack frame format codes
  localparam logic [3:0] FMT_FOUR = 4'h0;
  localparam logic [3:0] FMT_SIX = 4'h2;
  localparam logic [3:0] FMT_FAULT = 4'hC;
  // last word index of each frame (words count from zero)
  localparam logic [3:0] LAST_FOUR = 4'h3;
  localparam logic [3:0] LAST_SIX = 4'h5;
  localparam logic [3:0] LAST_FAULT = 4'hB;
  // byte offsets inside the bus fault frame
  localparam logic [4:0] OFS_PRE_SR = 5'h0C;
  localparam logic [4:0] OFS_FLT_FV = 5'h0E;
  localparam logic [4:0] OFS_FLT_PC = 5'h10;
  localparam logic [4:0] OFS_XCOUNT = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h16;
  // fault class held in the two top bits of the status word
  localparam logic [1:0] CLS_NORMAL = 2'h0;
  localparam logic [1:0] CLS_MOVE = 2'h1;
  localparam logic [1:0] CLS_EXCEPT = 2'h2;
  // status word bit positions
  localparam int STAT_FAULT_BIT = 15;
  localparam int STAT_MOVE_BIT = 14;
  localparam int STAT_TRACE_BIT = 12;
  localparam int STAT_BKPT_HI_BIT = 11;
  localparam int STAT_BKPT_LO_BIT = 10;
  // vector number used for the bus fault frame itself
  localparam logic [7:0] BUS_FAULT_VEC = 8'h02;
  // arbitrary revision code kept in the transfer count word
  localparam logic [7:0] UCODE_REV = 8'h5A;
  // exception kinds presented on the request port
  typedef enum logic [3:0] {
    BFR_K_INTR = 4'h0,
    BFR_K_FMTERR = 4'h1,
    BFR_K_TRAP = 4'h2,
    BFR_K_ILLEGAL = 4'h3,
    BFR_K_LINE = 4'h4,
    BFR_K_PRIV = 4'h5,
    BFR_K_BOUNDS = 4'h6,
    BFR_K_BOUNDS2 = 4'h7,
    BFR_K_CTRAP = 4'h8,
    BFR_K_VTRAP = 4'h9,
    BFR_K_DIVZ = 4'hA,
    BFR_K_TRACE = 4'hB,
    BFR_K_BKPT = 4'hC
  } bfr_kind_t;
endpackage : bfr_pkg

// [inc/bfr_word_if.sv]
`timescale 1ns/100ps
interface bfr_word_if;
  logic [3:0] idx;
  logic [3:0] fmt;
  logic [15:0] sr;
  logic [31:0] ret_pc;
  logic [15:0] fv;
  logic [31:0] faddr;
  logic [31:0] aux;
  logic [31:0] cur_pc;
  logic [15:0] xcount;
  logic [15:0] status;
  logic [15:0] word;
  modport gen (
    input idx, fmt, sr, ret_pc, fv, faddr, aux, cur_pc, xcount, status,
    output word
  );
  modport user (
    output idx, fmt, sr, ret_pc, fv, faddr, aux, cur_pc, xcount, status,
    input word
  );
endinterface : bfr_word_if

// [hdl/bfr_word_gen.sv]
`timescale 1ns/100ps
module bfr_word_gen (
  bfr_word_if.gen wif
);
  // head words shared by all three frames
  wire [15:0] head_word = (wif.idx == 4'h0) ? wif.sr :
                          (wif.idx == 4'h1) ? wif.ret_pc[31:16] :
                          (wif.idx == 4'h2) ? wif.ret_pc[15:0] : wif.fv;
  // tail words of the six-word frame
  wire [15:0] six_word = (wif.idx == 4'h4) ? wif.cur_pc[31:16] : wif.cur_pc[15:0];
  // tail words of the bus fault frame
  wire [15:0] fault_word = (wif.idx == 4'h4) ? wif.faddr[31:16] :
                           (wif.idx == 4'h5) ? wif.faddr[15:0] :
                           (wif.idx == 4'h6) ? wif.aux[31:16] :
                           (wif.idx == 4'h7) ? wif.aux[15:0] :
                           (wif.idx == 4'h8) ? wif.cur_pc[31:16] :
                           (wif.idx == 4'h9) ? wif.cur_pc[15:0] :
                           (wif.idx == 4'hA) ? wif.xcount : wif.status;
  // select by frame format
  assign wif.word = (wif.idx < 4'h4) ? head_word :
                    (wif.fmt == bfr_pkg::FMT_SIX) ? six_word : fault_word;
endmodule : bfr_word_gen

// [hdl/bfr_frame_unit.sv]
`timescale 1ns/100ps
// How it works
// - restartable fault return unstacks state, refetches and restarts the instruction
// - cleared continue flag turns move fault into full restart
// - unaltered move fault frame resumes at the faulted transfer
// - only the move continues; address not recomputed, mask rescanned as before
// - vector fetch or stacking fault gives same frame; address flags missing handler
// - exception fault return fetches handler, rebuilds original frame, resumes there
// - exception fault frame holds old status, format word, faulting address
// - fault address equal to stack pointer is recorded and recoverable
// - exactly three frames: four-word, six-word, twelve-word bus fault
// - four-word frame, format 0, for interrupts, traps, illegal, privilege
// - six-word frame, format 2, for check, trap conditions, divide, trace
// - breakpoints use six-word frame with the executing instruction address
// - top two status word bits give fault class 00, 01 or 10
// - transfer count reloaded from its low byte only with continue flag set
module bfr_frame_unit (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic exc_req,
  input wire logic [3:0] exc_kind,
  input wire logic [15:0] exc_sr,
  input wire logic [31:0] exc_next_pc,
  input wire logic [31:0] exc_fault_pc,
  input wire logic [7:0] exc_vector,
  input wire logic flt_req,
  input wire logic [1:0] flt_class,
  input wire logic [13:0] flt_status_low,
  input wire logic [31:0] flt_addr,
  input wire logic [31:0] flt_dbuf,
  input wire logic [7:0] flt_count,
  input wire logic [15:0] flt_orig_sr,
  input wire logic [15:0] flt_orig_fv,
  input wire logic [31:0] flt_orig_pc,
  input wire logic ret_req,
  input wire logic [15:0] ret_status,
  input wire logic [15:0] ret_xcount,
  input wire logic [15:0] ret_orig_fv,
  input wire logic [31:0] ret_fault_addr,
  input wire logic [31:0] ret_sp,
  input wire logic [31:0] vbr,
  output logic busy,
  output logic stk_valid,
  output logic stk_last,
  output logic [4:0] stk_offset,
  output logic [15:0] stk_data,
  output logic [3:0] stk_format,
  output logic ret_done,
  output logic ret_restart,
  output logic ret_continue,
  output logic [7:0] ret_reload_count,
  output logic ret_rebuild,
  output logic [3:0] ret_rebuild_format,
  output logic [31:0] ret_handler_vec_addr,
  output logic ret_unobtainable,
  output logic ret_sp_fault,
  output logic ret_requeue_trace,
  output logic ret_requeue_bkpt,
  output logic ret_rev_error
);
  typedef enum logic [1:0] {
    BFR_S_IDLE = 2'b01,
    BFR_S_STACK = 2'b10
  } bfr_state_t;
  // frame format chosen for a plain exception kind
  function automatic logic [3:0] bfr_kind_fmt(input logic [3:0] kind);
    bfr_kind_fmt = (kind >= 4'(bfr_pkg::BFR_K_BOUNDS)) ? bfr_pkg::FMT_SIX : bfr_pkg::FMT_FOUR;
  endfunction : bfr_kind_fmt
  // last word index of a frame format
  function automatic logic [3:0] bfr_last(input logic [3:0] fmt);
    bfr_last = (fmt == bfr_pkg::FMT_FOUR) ? bfr_pkg::LAST_FOUR :
               (fmt == bfr_pkg::FMT_SIX) ? bfr_pkg::LAST_SIX : bfr_pkg::LAST_FAULT;
  endfunction : bfr_last

  bfr_state_t state;
  bfr_state_t next_state;
  logic [3:0] idx;
  logic [3:0] fmt;
  logic [15:0] cap_sr;
  logic [31:0] cap_ret_pc;
  logic [15:0] cap_fv;
  logic [31:0] cap_faddr;
  logic [31:0] cap_aux;
  logic [31:0] cap_cur_pc;
  logic [15:0] cap_xcount;
  logic [15:0] cap_status;
  bfr_word_if wif ();
  bfr_word_gen bfr_word_gen_inst (
    .wif(wif.gen)
  );
  // request decode, bus fault ahead of exception ahead of return
  wire idle = (state == BFR_S_IDLE);
  wire take_flt = idle && flt_req;
  wire take_exc = idle && exc_req && !flt_req;
  wire take_ret = idle && ret_req && !flt_req && !exc_req;
  wire at_last = (idx == bfr_last(fmt));
  wire [3:0] exc_fmt = bfr_kind_fmt(exc_kind);
  wire [15:0] exc_fv = {exc_fmt, 2'b00, exc_vector, 2'b00};
  wire [15:0] flt_fv = {bfr_pkg::FMT_FAULT, 2'b00, bfr_pkg::BUS_FAULT_VEC, 2'b00};
  wire flt_is_exc = (flt_class == bfr_pkg::CLS_EXCEPT);
  // class into the top status bits
  wire [15:0] flt_status = {flt_class, flt_status_low};
  // return decode from the stacked status word
  wire r_fault = ret_status[bfr_pkg::STAT_FAULT_BIT];
  wire r_move = ret_status[bfr_pkg::STAT_MOVE_BIT];
  wire [31:0] r_vec_addr = vbr + {20'h00000, ret_orig_fv[11:0]};
  // word generator fed from the captured frame
  assign wif.idx = idx;
  assign wif.fmt = fmt;
  assign wif.sr = cap_sr;
  assign wif.ret_pc = cap_ret_pc;
  assign wif.fv = cap_fv;
  assign wif.faddr = cap_faddr;
  assign wif.aux = cap_aux;
  assign wif.cur_pc = cap_cur_pc;
  assign wif.xcount = cap_xcount;
  assign wif.status = cap_status;
  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      BFR_S_IDLE: begin
        if (take_flt || take_exc) begin
          next_state = BFR_S_STACK;
        end
      end
      BFR_S_STACK: begin
        if (at_last) begin
          next_state = BFR_S_IDLE;
        end
      end
      default: begin
        next_state = BFR_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= BFR_S_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // word counter during stacking
  always_ff @(posedge clk) begin
    if (!rst_b || idle || at_last) begin
      idx <= 4'h0;
    end else begin
      idx <= idx + 4'h1;
    end
  end

  // capture frame contents on a bus fault or a plain exception
  // only three formats
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fmt <= bfr_pkg::FMT_FOUR;
      cap_sr <= 16'h0000;
      cap_ret_pc <= 32'h00000000;
      cap_fv <= 16'h0000;
      cap_cur_pc <= 32'h00000000;
    end else if (take_flt) begin
      fmt <= bfr_pkg::FMT_FAULT;
      cap_sr <= exc_sr;
      cap_ret_pc <= exc_next_pc;
      cap_fv <= flt_fv;
      cap_cur_pc <= (flt_is_exc && flt_orig_fv[15:12] != bfr_pkg::FMT_SIX) ?
                    32'h00000000 : (flt_is_exc ? flt_orig_pc : exc_fault_pc);
    end else if (take_exc) begin
      fmt <= exc_fmt;
      cap_sr <= exc_sr;
      cap_ret_pc <= exc_next_pc;
      cap_fv <= exc_fv;
      cap_cur_pc <= exc_fault_pc;
    end
  end

  // bus fault specific words
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cap_faddr <= 32'h00000000;
      cap_aux <= 32'h00000000;
      cap_xcount <= 16'h0000;
      cap_status <= 16'h0000;
    end else if (take_flt) begin
      // same frame, only the address differs
      cap_faddr <= flt_addr;
      cap_aux <= flt_is_exc ? {flt_orig_sr, flt_orig_fv} : flt_dbuf;
      cap_xcount <= {bfr_pkg::UCODE_REV, flt_count};
      cap_status <= flt_status;
    end
  end
  // registered stacking port and busy flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stk_valid <= 1'b0;
      stk_last <= 1'b0;
      stk_offset <= 5'h00;
      stk_data <= 16'h0000;
      stk_format <= bfr_pkg::FMT_FOUR;
      busy <= 1'b0;
    end else begin
      stk_valid <= (state == BFR_S_STACK);
      stk_last <= (state == BFR_S_STACK) && at_last;
      stk_offset <= {idx, 1'b0};
      stk_data <= wif.word;
      stk_format <= fmt;
      busy <= (next_state == BFR_S_STACK);
    end
  end
  // return decision, taken in one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ret_done <= 1'b0;
      ret_restart <= 1'b0;
      ret_continue <= 1'b0;
      ret_reload_count <= 8'h00;
      ret_rebuild <= 1'b0;
      ret_rebuild_format <= bfr_pkg::FMT_FOUR;
      ret_handler_vec_addr <= 32'h00000000;
      ret_unobtainable <= 1'b0;
      ret_sp_fault <= 1'b0;
      ret_requeue_trace <= 1'b0;
      ret_requeue_bkpt <= 1'b0;
      ret_rev_error <= 1'b0;
    end else begin
      ret_done <= take_ret;
      if (take_ret) begin
        ret_restart <= !r_fault && !r_move;
        ret_continue <= !r_fault && r_move;
        // count used only with continue flag
        ret_reload_count <= r_move ? ret_xcount[7:0] : 8'h00;
        ret_rebuild <= r_fault;
        ret_rebuild_format <= ret_orig_fv[15:12];
        ret_handler_vec_addr <= r_vec_addr;
        ret_unobtainable <= r_fault && (ret_fault_addr == r_vec_addr);
        // stacking fault with good fault frame
        ret_sp_fault <= r_fault && (ret_fault_addr == ret_sp);
        ret_requeue_trace <= ret_status[bfr_pkg::STAT_TRACE_BIT];
        ret_requeue_bkpt <= ret_status[bfr_pkg::STAT_BKPT_HI_BIT] |
                            ret_status[bfr_pkg::STAT_BKPT_LO_BIT];
        ret_rev_error <= (ret_xcount[15:8] != bfr_pkg::UCODE_REV);
      end
    end
  end
  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    take_ret && ret_status[15:14] == 2'b00 |=> ret_done && ret_restart && !ret_continue)
    else $error("normal fault return did not restart");
  AST_CONVERT: assert property (@(posedge clk) disable iff (!rst_b)
    take_ret && !ret_status[14] |=> !ret_continue)
    else $error("cleared continue flag still continued");
  AST_CONTINUE: assert property (@(posedge clk) disable iff (!rst_b)
    take_ret && ret_status[15:14] == 2'b01 |=> ret_continue && !ret_restart)
    else $error("move fault return did not continue");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
    take_ret |=> ret_reload_count == ($past(ret_status[14]) ? $past(ret_xcount[7:0]) : 8'h00))
    else $error("transfer count reload wrong");
  AST_REBUILD: assert property (@(posedge clk) disable iff (!rst_b)
    take_ret && ret_status[15] |=> ret_rebuild && ret_handler_vec_addr == $past(r_vec_addr))
    else $error("exception fault return did not rebuild");
  AST_SP_FAULT: assert property (@(posedge clk) disable iff (!rst_b)
    take_ret && ret_status[15] && ret_fault_addr == ret_sp |=> ret_sp_fault)
    else $error("stack pointer fault not flagged");
  AST_FOUR: assert property (@(posedge clk) disable iff (!rst_b)
    take_exc && exc_kind < 4'h6 |=> ##1 stk_valid && stk_format == 4'h0 && stk_data == $past(exc_sr, 2))
    else $error("four-word frame wrong");
  AST_SIX: assert property (@(posedge clk) disable iff (!rst_b)
    take_exc && exc_kind >= 4'h6 && exc_kind <= 4'hC |=> ##1 stk_format == 4'h2 ##5 stk_last)
    else $error("six-word frame wrong");
  AST_LENGTH: assert property (@(posedge clk) disable iff (!rst_b)
    stk_valid && stk_last |-> stk_offset == 5'h06 || stk_offset == 5'h0A || stk_offset == 5'h16)
    else $error("frame length not four, six or twelve words");
  AST_CLASS: assert property (@(posedge clk) disable iff (!rst_b)
    take_flt |=> ##12 stk_last && stk_data[15:14] == $past(flt_class, 13))
    else $error("fault class bits wrong");
  AST_PRE_SR: assert property (@(posedge clk) disable iff (!rst_b)
    take_flt && flt_is_exc |=> ##7 stk_offset == 5'h0C && stk_data == $past(flt_orig_sr, 8))
    else $error("pre-exception status misplaced");
endmodule : bfr_frame_unit

// [sim/bfr_frame_unit_tb.sv]
`timescale 1ns/100ps
module bfr_frame_unit_tb;
  logic clk, rst_b, exc_req, flt_req, ret_req;
  logic [3:0] exc_kind;
  logic [15:0] exc_sr, flt_orig_sr, flt_orig_fv, ret_status, ret_xcount, ret_orig_fv;
  logic [31:0] exc_next_pc, exc_fault_pc, flt_addr, flt_dbuf, flt_orig_pc;
  logic [31:0] ret_fault_addr, ret_sp, vbr, ret_handler_vec_addr;
  logic [7:0] exc_vector, flt_count, ret_reload_count;
  logic [1:0] flt_class;
  logic [13:0] flt_status_low;
  logic busy, stk_valid, stk_last, ret_done, ret_restart, ret_continue, ret_rebuild;
  logic ret_unobtainable, ret_sp_fault, ret_requeue_trace, ret_requeue_bkpt, ret_rev_error;
  logic [4:0] stk_offset;
  logic [15:0] stk_data;
  logic [3:0] stk_format, ret_rebuild_format;
  logic [15:0] exp_w [0:11];
  logic [3:0] exp_fmt;
  int n_exp;
  int fail_count;
  int cmp_count;

  bfr_frame_unit bfr_frame_unit_inst (
    .clk(clk), .rst_b(rst_b), .exc_req(exc_req), .exc_kind(exc_kind), .exc_sr(exc_sr),
    .exc_next_pc(exc_next_pc), .exc_fault_pc(exc_fault_pc), .exc_vector(exc_vector),
    .flt_req(flt_req), .flt_class(flt_class), .flt_status_low(flt_status_low),
    .flt_addr(flt_addr), .flt_dbuf(flt_dbuf), .flt_count(flt_count),
    .flt_orig_sr(flt_orig_sr), .flt_orig_fv(flt_orig_fv), .flt_orig_pc(flt_orig_pc),
    .ret_req(ret_req), .ret_status(ret_status), .ret_xcount(ret_xcount),
    .ret_orig_fv(ret_orig_fv), .ret_fault_addr(ret_fault_addr), .ret_sp(ret_sp),
    .vbr(vbr), .busy(busy), .stk_valid(stk_valid), .stk_last(stk_last),
    .stk_offset(stk_offset), .stk_data(stk_data), .stk_format(stk_format),
    .ret_done(ret_done), .ret_restart(ret_restart), .ret_continue(ret_continue),
    .ret_reload_count(ret_reload_count), .ret_rebuild(ret_rebuild),
    .ret_rebuild_format(ret_rebuild_format), .ret_handler_vec_addr(ret_handler_vec_addr),
    .ret_unobtainable(ret_unobtainable), .ret_sp_fault(ret_sp_fault),
    .ret_requeue_trace(ret_requeue_trace), .ret_requeue_bkpt(ret_requeue_bkpt),
    .ret_rev_error(ret_rev_error)
  );

  // free-running 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // one comparison, counted and reported
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // counts and verdict, then stop
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // one request, then every stacked word against exp_w
  task automatic run_stack(input logic is_flt);
    int k;
    @(posedge clk);
    #1;
    if (is_flt) flt_req = 1'b1;
    else exc_req = 1'b1;
    @(posedge clk);
    #1;
    exc_req = 1'b0;
    flt_req = 1'b0;
    for (k = 0; k < 8 && stk_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (stk_valid !== 1'b1) begin
      check("stk_valid wait", 32'h1, 32'(stk_valid));
      tally_and_finish();
    end
    check("busy", 32'h1, 32'(busy));
    for (k = 0; k < n_exp; k++) begin
      check("stk_valid", 32'h1, 32'(stk_valid));
      check("busy", 32'(k < n_exp - 1), 32'(busy));
      check("stk_offset", 32'(2 * k), 32'(stk_offset));
      check("stk_data", 32'(exp_w[k]), 32'(stk_data));
      check("stk_format", 32'(exp_fmt), 32'(stk_format));
      check("stk_last", 32'(k == n_exp - 1), 32'(stk_last));
      @(posedge clk);
      #1;
    end
    check("stk_valid end", 32'h0, 32'(stk_valid));
  endtask : run_stack

  // normal frame contents for one kind
  task automatic normal(input int k, input logic six);
    exc_kind = 4'(k);
    exc_sr = 16'h2700 + 16'(k);
    exc_next_pc = 32'h0001_2340 + 32'(k);
    exc_fault_pc = 32'h00AB_CD00 + 32'(k);
    exc_vector = 8'h20 + 8'(k);
    exp_fmt = six ? bfr_pkg::FMT_SIX : bfr_pkg::FMT_FOUR;
    n_exp = six ? 6 : 4;
    exp_w[0] = exc_sr;
    exp_w[1] = exc_next_pc[31:16];
    exp_w[2] = exc_next_pc[15:0];
    exp_w[3] = {exp_fmt, 2'h0, exc_vector, 2'h0};
    exp_w[4] = exc_fault_pc[31:16];
    exp_w[5] = exc_fault_pc[15:0];
    run_stack(1'b0);
  endtask : normal

  // kinds 0..5 give the four-word frame
  task automatic scen_four;
    for (int k = 0; k < 6; k++) normal(k, 1'b0);
  endtask : scen_four

  // kinds 6..12 give the six-word frame, breakpoint included
  task automatic scen_six;
    for (int k = 6; k < 13; k++) normal(k, 1'b1);
  endtask : scen_six

  // bus fault frame for each class, class 2 with six- and four-word originals
  task automatic scen_fault;
    logic [1:0] cls;
    for (int c = 0; c < 4; c++) begin
      cls = (c > 1) ? 2'h2 : 2'(c);
      flt_class = cls;
      flt_status_low = 14'h1C05 + 14'(c);
      flt_addr = 32'h0040_0010 + 32'(c);
      flt_dbuf = 32'hBEEF_0000 + 32'(c);
      flt_count = 8'h0B + 8'(c);
      flt_orig_sr = 16'h2004;
      flt_orig_fv = (c == 3) ? 16'h0080 : 16'h2018;
      flt_orig_pc = 32'h0000_7770;
      exc_sr = 16'h2710;
      exc_next_pc = 32'h0000_9000;
      exc_fault_pc = 32'h0000_8FFE;
      exp_fmt = bfr_pkg::FMT_FAULT;
      n_exp = 12;
      exp_w[0] = exc_sr;
      exp_w[1] = exc_next_pc[31:16];
      exp_w[2] = exc_next_pc[15:0];
      exp_w[3] = {bfr_pkg::FMT_FAULT, 2'h0, bfr_pkg::BUS_FAULT_VEC, 2'h0};
      exp_w[4] = flt_addr[31:16];
      exp_w[5] = flt_addr[15:0];
      exp_w[6] = (cls == 2'h2) ? flt_orig_sr : flt_dbuf[31:16];
      exp_w[7] = (cls == 2'h2) ? flt_orig_fv : flt_dbuf[15:0];
      exp_w[8] = (cls != 2'h2) ? exc_fault_pc[31:16] : (c == 2) ? flt_orig_pc[31:16] : 16'h0;
      exp_w[9] = (cls != 2'h2) ? exc_fault_pc[15:0] : (c == 2) ? flt_orig_pc[15:0] : 16'h0;
      exp_w[10] = {bfr_pkg::UCODE_REV, flt_count};
      exp_w[11] = {cls, flt_status_low};
      run_stack(1'b1);
    end
  endtask : scen_fault

  // one return decision; flags are restart,continue,rebuild,unobt,sp,trace,bkpt,rev
  task automatic do_ret(input logic [15:0] s, input logic [15:0] x, input logic [15:0] f,
                        input logic [31:0] fa, input logic [7:0] ef, input logic [7:0] er);
    @(posedge clk);
    #1;
    ret_req = 1'b1;
    ret_status = s;
    ret_xcount = x;
    ret_orig_fv = f;
    ret_fault_addr = fa;
    @(posedge clk);
    #1;
    ret_req = 1'b0;
    check("ret_done", 32'h1, 32'(ret_done));
    check("ret_flags", 32'(ef), 32'({ret_restart, ret_continue, ret_rebuild,
          ret_unobtainable, ret_sp_fault, ret_requeue_trace, ret_requeue_bkpt, ret_rev_error}));
    check("ret_reload_count", 32'(er), 32'(ret_reload_count));
    @(posedge clk);
    #1;
    check("ret_done pulse", 32'h0, 32'(ret_done));
  endtask : do_ret

  // each kind of return from a handler
  task automatic scen_return;
    ret_sp = 32'h0000_3000;
    do_ret(16'h0000, 16'h5A07, 16'h0, 32'h0, 8'h80, 8'h00);
    do_ret(16'h5C00, 16'h5A09, 16'h0, 32'h0, 8'h46, 8'h09);
    do_ret(16'h1400, 16'h5A09, 16'h0, 32'h0, 8'h86, 8'h00);
    do_ret(16'hC000, 16'h5A03, 16'h2018, 32'h0, 8'h20, 8'h03);
    do_ret(16'h0000, 16'h3307, 16'h0, 32'h0, 8'h81, 8'h00);
    do_ret(16'h8000, 16'h5A00, 16'h2018, 32'h0000_1018, 8'h30, 8'h00);
    check("handler", 32'h0000_1018, ret_handler_vec_addr);
    check("rebuild_fmt", 32'h2, 32'(ret_rebuild_format));
    do_ret(16'h8000, 16'h5A00, 16'h0080, 32'h0000_3000, 8'h28, 8'h00);
    check("handler", 32'h0000_1080, ret_handler_vec_addr);
    check("rebuild_fmt", 32'h0, 32'(ret_rebuild_format));
  endtask : scen_return

  // reset, then the scenarios in turn
  initial begin
    {rst_b, exc_req, flt_req, ret_req, exc_kind, exc_sr, exc_vector} = '0;
    {exc_next_pc, exc_fault_pc, flt_class, flt_status_low, flt_addr, flt_dbuf} = '0;
    {flt_count, flt_orig_sr, flt_orig_fv, flt_orig_pc} = '0;
    {ret_status, ret_xcount, ret_orig_fv, ret_fault_addr, ret_sp} = '0;
    vbr = 32'h0000_1000;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    check("busy after reset", 32'h0, 32'(busy));
    scen_four();
    scen_six();
    scen_fault();
    scen_return();
    tally_and_finish();
  end
endmodule : bfr_frame_unit_tb
